// ===== logic/cpu_scan_regs.svh
`ifndef CPU_SCAN_REGS_SVH
`define CPU_SCAN_REGS_SVH

// Chain length and field offsets, counted from the end that shifts out first.
`define CHAIN_LEN          192
`define CHAIN_WBH_LSB      0
`define CHAIN_WBL_LSB      32
`define CHAIN_MSW_LSB      64
`define CHAIN_PC_LSB       96
`define CHAIN_OPC_LSB      128
`define CHAIN_CTL_LSB      160

// Control-state word field positions (bit 0 is the least significant).
`define CTL_BACKUP_LSB     0
`define CTL_STATUS_LSB     0
`define CTL_ENC_BIT        1
`define CTL_FORCE_BIT      10
`define CTL_PC_INVALID_FLAG_BIT      11
`define CTL_STATE_LSB      12
`define CTL_STATE_W        4
`define CTL_BACKUP_POS     16

// Reset word and backup amount values.
`define RST_WORD           32'h0000_0000
`define BACKUP_NONE        4'h0
`define BACKUP_MAX         4'h5
`define BACKUP_STEP        32'h0000_0004

`endif

// ===== logic/cpu_scan_pkg.sv
package cpu_scan_pkg;

    // Core state seen at debug entry or handed back for a step or exit.
    typedef struct packed {
        logic [31:0] ctl;
        logic [31:0] opcode;
        logic [31:0] pc;
        logic [31:0] msw;
        logic [31:0] wb_low;
        logic [31:0] wb_high;
    } core_state_type;

    // Test access port controller states.
    typedef enum logic [3:0] {
        TAP_RESET   = 4'h0,
        TAP_IDLE    = 4'h1,
        TAP_SEL_DR  = 4'h2,
        TAP_CAP_DR  = 4'h3,
        TAP_SH_DR   = 4'h4,
        TAP_EX1_DR  = 4'h5,
        TAP_PAU_DR  = 4'h6,
        TAP_EX2_DR  = 4'h7,
        TAP_UPD_DR  = 4'h8,
        TAP_SEL_IR  = 4'h9,
        TAP_CAP_IR  = 4'ha,
        TAP_SH_IR   = 4'hb,
        TAP_EX1_IR  = 4'hc,
        TAP_PAU_IR  = 4'hd,
        TAP_EX2_IR  = 4'he,
        TAP_UPD_IR  = 4'hf
    } tap_state_type;

endpackage : cpu_scan_pkg

// ===== logic/cpu_debug_scan_chain.sv
// How it works
// RULE1 - On debug entry the next opcode is captured into the opcode slot.
// RULE2 - Tool saves the captured opcode if it means to resume.
// RULE3 - A scanned opcode is handed to the core for a single step.
// RULE4 - Control-state word is captured at debug entry, before any change.
// RULE5 - Tool restores or clears internal state bits before stepping or exit.
// RULE6 - Backup amount code 0 none, 1 to 5 subtract 4 to 20.
// RULE7 - Tool subtracts the backup amount from the PC before resuming.
// RULE8 - Tool loads a no-op when the backup amount is nonzero.
// RULE9 - Preferred no-ops: fixed 0x60000000, variable 0x1800D000.
// RULE10 - Invalid flag marks corrupt PC and opcode and overrides backup.
// RULE11 - Tool writes valid PC and opcode when the invalid flag was set.
// RULE12 - Force flag makes low write-back the first source operand.
// RULE13 - Encoding flag tells fixed or variable length opcode.
// RULE14 - PC captured at entry; tool restores it before exit.
// RULE15 - No-op plus PC before target redirects fetch to target.
// RULE16 - Stepped result lands in write-back buffer; scanned operands used.
// RULE17 - High write-back half only for 64-bit vector work.
// RULE18 - Tool saves and restores the machine state word.
// RULE19 - Arbitrary start: PC is target minus 4 with a no-op.
// RULE20 - Step command has launch set and leave-debug clear.
// RULE21 - Scanned values reach the core only at update, never mid-shift.
`timescale 1ns/1ps
`include "cpu_scan_regs.svh"

module cpu_debug_scan_chain #(
    parameter int CHAIN_LEN = `CHAIN_LEN
) (
    // Clock and reset.
    input  wire logic                         CORE_CLK,
    input  wire logic                         ARST_N,
    // Test port pins; the inputs come from outside the clock domain.
    input  wire logic                         TCK,
    input  wire logic                         TMS,
    input  wire logic                         TDI,
    output logic                              TDO,
    output logic                              TDO_OE,
    // Chain selected by the debug command word.
    input  wire logic                         CHAIN_SEL,
    // Core side.
    input  wire logic                         DEBUG_ENTRY,
    input  wire cpu_scan_pkg::core_state_type ENTRY_STATE,
    input  wire logic                         STEP_DONE,
    input  wire logic [31:0]                  STEP_RESULT_LOW,
    input  wire logic [31:0]                  STEP_RESULT_HIGH,
    input  wire logic                         STEP_IS_VECTOR,
    output cpu_scan_pkg::core_state_type      APPLY_STATE,
    output logic                              APPLY_STROBE,
    output logic                              FORCE_OPERAND,
    output logic [31:0]                       FORCE_OPERAND_VALUE,
    output logic [31:0]                       RESUME_PC_HINT
);

    // The field layout is fixed, so only the documented length can work.
    if (CHAIN_LEN != `CHAIN_LEN) begin : g_bad_len
        $error("chain length must match the field layout");
    end

    // Pin synchronisers; stage one is read only by stage two.
    logic [2:0] tck_s1_ff, tck_s2_ff;
    logic       tck_d_ff;
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tck_s1_ff <= 3'h0;
            tck_s2_ff <= 3'h0;
            tck_d_ff  <= 1'b0;
        end else begin
            tck_s1_ff <= {TCK, TMS, TDI};
            tck_s2_ff <= tck_s1_ff;
            tck_d_ff  <= tck_s2_ff[2];
        end
    end

    logic tck_rise, tck_fall, tms_s, tdi_s;
    assign tck_rise = tck_s2_ff[2] & ~tck_d_ff;
    assign tck_fall = ~tck_s2_ff[2] & tck_d_ff;
    assign tms_s    = tck_s2_ff[1];
    assign tdi_s    = tck_s2_ff[0];

    function automatic cpu_scan_pkg::tap_state_type tap_next(
        input cpu_scan_pkg::tap_state_type s, input logic m);
        case (s)
            cpu_scan_pkg::TAP_RESET:
                tap_next = m ? s : cpu_scan_pkg::TAP_IDLE;
            cpu_scan_pkg::TAP_IDLE:
                tap_next = m ? cpu_scan_pkg::TAP_SEL_DR : s;
            cpu_scan_pkg::TAP_SEL_DR: tap_next = m ? cpu_scan_pkg::TAP_SEL_IR
                                                   : cpu_scan_pkg::TAP_CAP_DR;
            cpu_scan_pkg::TAP_CAP_DR,
            cpu_scan_pkg::TAP_SH_DR:  tap_next = m ? cpu_scan_pkg::TAP_EX1_DR
                                                   : cpu_scan_pkg::TAP_SH_DR;
            cpu_scan_pkg::TAP_EX1_DR: tap_next = m ? cpu_scan_pkg::TAP_UPD_DR
                                                   : cpu_scan_pkg::TAP_PAU_DR;
            cpu_scan_pkg::TAP_PAU_DR:
                tap_next = m ? cpu_scan_pkg::TAP_EX2_DR : s;
            cpu_scan_pkg::TAP_EX2_DR: tap_next = m ? cpu_scan_pkg::TAP_UPD_DR
                                                   : cpu_scan_pkg::TAP_SH_DR;
            cpu_scan_pkg::TAP_SEL_IR: tap_next = m ? cpu_scan_pkg::TAP_RESET
                                                   : cpu_scan_pkg::TAP_CAP_IR;
            cpu_scan_pkg::TAP_CAP_IR,
            cpu_scan_pkg::TAP_SH_IR:  tap_next = m ? cpu_scan_pkg::TAP_EX1_IR
                                                   : cpu_scan_pkg::TAP_SH_IR;
            cpu_scan_pkg::TAP_EX1_IR: tap_next = m ? cpu_scan_pkg::TAP_UPD_IR
                                                   : cpu_scan_pkg::TAP_PAU_IR;
            cpu_scan_pkg::TAP_PAU_IR:
                tap_next = m ? cpu_scan_pkg::TAP_EX2_IR : s;
            cpu_scan_pkg::TAP_EX2_IR: tap_next = m ? cpu_scan_pkg::TAP_UPD_IR
                                                   : cpu_scan_pkg::TAP_SH_IR;
            cpu_scan_pkg::TAP_UPD_DR,
            cpu_scan_pkg::TAP_UPD_IR: tap_next = m ? cpu_scan_pkg::TAP_SEL_DR
                                                   : cpu_scan_pkg::TAP_IDLE;
            default:                  tap_next = cpu_scan_pkg::TAP_RESET;
        endcase
    endfunction : tap_next

    cpu_scan_pkg::tap_state_type tap_ff;
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tap_ff <= cpu_scan_pkg::TAP_RESET;
        end else if (tck_rise) begin
            tap_ff <= tap_next(tap_ff, tms_s);
        end
    end

    // The documented state: six words held for the core.
    cpu_scan_pkg::core_state_type state_ff;
    logic [CHAIN_LEN-1:0]         shift_ff;
    logic                         entry_d_ff;
    logic                         in_debug_ff;
    logic                         apply_ff;

    logic sel_cap, sel_shift, sel_upd, entry_pulse;
    assign sel_cap   = CHAIN_SEL & tck_rise
                     & (tap_ff == cpu_scan_pkg::TAP_CAP_DR);
    assign sel_shift = CHAIN_SEL & tck_rise
                     & (tap_ff == cpu_scan_pkg::TAP_SH_DR);
    assign sel_upd   = CHAIN_SEL & tck_rise
                     & (tap_ff == cpu_scan_pkg::TAP_UPD_DR);
    assign entry_pulse = DEBUG_ENTRY & ~entry_d_ff;

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            entry_d_ff  <= 1'b0;
            in_debug_ff <= 1'b0;
        end else begin
            entry_d_ff  <= DEBUG_ENTRY;
            in_debug_ff <= DEBUG_ENTRY;
        end
    end

    cpu_scan_pkg::core_state_type entry_fix;
    always_comb begin
        entry_fix = ENTRY_STATE; // see RULE13
        // Invalid flag wins: backup amount is meaningless and reads zero.
        if (ENTRY_STATE.ctl[`CTL_PC_INVALID_FLAG_BIT]) begin // see RULE10
            entry_fix.ctl[`CTL_BACKUP_POS +: 4] = `BACKUP_NONE;
        end else if (ENTRY_STATE.ctl[`CTL_BACKUP_POS +: 4] > `BACKUP_MAX) begin
            entry_fix.ctl[`CTL_BACKUP_POS +: 4] = `BACKUP_NONE; // see RULE6
        end
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_ff <= '0;
        end else if (entry_pulse) begin
            // Opcode, control, PC and machine state caught before any step.
            state_ff <= entry_fix; // see RULE1 see RULE4 see RULE14
        end else if (STEP_DONE) begin
            state_ff.wb_low <= STEP_RESULT_LOW; // see RULE16
            if (STEP_IS_VECTOR) begin
                state_ff.wb_high <= STEP_RESULT_HIGH; // see RULE17
            end
        end else if (sel_upd) begin
            state_ff <= shift_ff; // see RULE21
        end
    end

    // Shift register: loaded at capture, shifted LSB first, applied at update.
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            shift_ff <= '0;
        end else if (sel_cap) begin
            shift_ff <= state_ff;
        end else if (sel_shift) begin
            shift_ff <= {tdi_s, shift_ff[CHAIN_LEN-1:1]};
        end
    end

    // Apply pulse tells the core that a complete chain is ready to use.
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            apply_ff <= 1'b0;
        end else begin
            apply_ff <= sel_upd & in_debug_ff; // see RULE21 see RULE3
        end
    end

    // Data out changes on the falling test clock while shifting.
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            TDO    <= 1'b0;
            TDO_OE <= 1'b0;
        end else if (tck_fall) begin
            TDO    <= shift_ff[0];
            TDO_OE <= CHAIN_SEL & (tap_ff == cpu_scan_pkg::TAP_SH_DR);
        end
    end

    logic [3:0]  backup;
    logic [31:0] backup_bytes;
    assign backup       = state_ff.ctl[`CTL_BACKUP_POS +: 4];
    assign backup_bytes = 32'(backup) * `BACKUP_STEP; // see RULE6

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            RESUME_PC_HINT <= `RST_WORD;
        end else begin
            RESUME_PC_HINT <= state_ff.ctl[`CTL_PC_INVALID_FLAG_BIT]
                ? state_ff.pc : state_ff.pc - backup_bytes; // see RULE10
        end
    end

    assign APPLY_STATE         = state_ff; // see RULE3 see RULE15
    assign APPLY_STROBE        = apply_ff;
    assign FORCE_OPERAND       = state_ff.ctl[`CTL_FORCE_BIT]; // see RULE12
    assign FORCE_OPERAND_VALUE = state_ff.wb_low; // see RULE12 see RULE17

endmodule : cpu_debug_scan_chain

// ===== tb/cpu_scan_sva.sv
`timescale 1ns/1ps
module cpu_scan_sva #(
    parameter int CHAIN_LEN = 192
) (
    // Clock and reset.
    input wire logic                         CORE_CLK,
    input wire logic                         ARST_N,
    // Watched ports.
    input wire logic                         TDO_OE,
    input wire logic                         DEBUG_ENTRY,
    input wire cpu_scan_pkg::core_state_type ENTRY_STATE,
    input wire logic                         STEP_DONE,
    input wire logic [31:0]                  STEP_RESULT_LOW,
    input wire logic                         STEP_IS_VECTOR,
    input wire cpu_scan_pkg::core_state_type APPLY_STATE,
    input wire logic                         APPLY_STROBE,
    input wire logic                         FORCE_OPERAND,
    input wire logic [31:0]                  FORCE_OPERAND_VALUE,
    input wire logic [31:0]                  RESUME_PC_HINT
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!ARST_N);
    AST_ENTRY_CAPTURE: assert property ($rose(DEBUG_ENTRY) |->
        ##[1:3] (APPLY_STATE.opcode == ENTRY_STATE.opcode &&
                 APPLY_STATE.pc == ENTRY_STATE.pc))
        else $error("entry not captured");
    AST_STROBE_ONE: assert property (APPLY_STROBE |=>
        !APPLY_STROBE) else $error("strobe longer than one cycle");
    // The strobe leaves its register two edges after the debug entry input is seen.
    AST_STROBE_DEBUG: assert property (APPLY_STROBE |->
        $past(DEBUG_ENTRY, 2)) else $error("strobe outside debug");
    AST_SHIFT_HOLD: assert property (TDO_OE && $past(TDO_OE) &&
        !$past(STEP_DONE) |-> $stable(APPLY_STATE))
        else $error("mid-shift change");
    AST_FORCE: assert property ($stable(APPLY_STATE) |->
        FORCE_OPERAND == APPLY_STATE.ctl[10] &&
        FORCE_OPERAND_VALUE == APPLY_STATE.wb_low)
        else $error("force operand wrong");
    AST_HINT_INVALID: assert property ($stable(APPLY_STATE) &&
        APPLY_STATE.ctl[11] |-> RESUME_PC_HINT == APPLY_STATE.pc)
        else $error("invalid hint wrong");
    AST_HINT_BACKUP: assert property ($stable(APPLY_STATE) &&
        !APPLY_STATE.ctl[11] |-> RESUME_PC_HINT ==
        APPLY_STATE.pc - {26'h0, APPLY_STATE.ctl[19:16], 2'h0})
        else $error("backup hint wrong");
    AST_STEP_LOW: assert property (STEP_DONE |-> ##[1:2]
        APPLY_STATE.wb_low == STEP_RESULT_LOW) else $error("step result lost");
    AST_STEP_HIGH: assert property (STEP_DONE &&
        !STEP_IS_VECTOR |=> $stable(APPLY_STATE.wb_high))
        else $error("high half touched");
    cover property (APPLY_STROBE);
    cover property ($rose(DEBUG_ENTRY));
    cover property (STEP_DONE && STEP_IS_VECTOR);
    cover property (TDO_OE);
endmodule : cpu_scan_sva
bind cpu_debug_scan_chain cpu_scan_sva #(.CHAIN_LEN(CHAIN_LEN)) u_cpu_scan_sva (
    .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .TDO_OE(TDO_OE),
    .DEBUG_ENTRY(DEBUG_ENTRY), .ENTRY_STATE(ENTRY_STATE), .STEP_DONE(STEP_DONE),
    .STEP_RESULT_LOW(STEP_RESULT_LOW), .STEP_IS_VECTOR(STEP_IS_VECTOR),
    .APPLY_STATE(APPLY_STATE), .APPLY_STROBE(APPLY_STROBE),
    .FORCE_OPERAND(FORCE_OPERAND), .FORCE_OPERAND_VALUE(FORCE_OPERAND_VALUE),
    .RESUME_PC_HINT(RESUME_PC_HINT));

// ===== tb/jtag_tool.sv
`timescale 1ns/1ps
module jtag_tool (
    // Test port pins.
    output logic     TCK,
    output logic     TMS,
    output logic     TDI,
    input wire logic TDO
);
    // The test clock stands low between frames.
    initial begin
        TCK = 1'b0;
        TMS = 1'b1;
        TDI = 1'b0;
    end
    task automatic tick(input logic m, input logic d, output logic q);
        TMS = m;
        TDI = d;
        #80;
        TCK = 1'b1;
        q = TDO;
        #80;
        TCK = 1'b0;
    endtask : tick
    // Capture, shift and update; the old chain comes back for saving.
    task automatic scan(input logic [191:0] din, output logic [191:0] dout);
        logic q;
        tick(1'b0, TDI, q);
        tick(1'b1, TDI, q);
        tick(1'b0, TDI, q);
        tick(1'b0, TDI, q);
        for (int i = 0; i < 192; i++) begin
            tick(i == 191, din[i], q);
            dout[i] = q;
        end
        tick(1'b1, ~TDI, q);
        tick(1'b0, ~TDI, q);
    endtask : scan
endmodule : jtag_tool

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {
        logic [31:0] ctl_in;
        logic [31:0] ctl_exp;
        logic [31:0] hint;
    } row_type;
    logic CORE_CLK = 1'b0, ARST_N = 1'b0, CHAIN_SEL = 1'b0;
    logic DEBUG_ENTRY = 1'b0, STEP_DONE = 1'b0, STEP_IS_VECTOR = 1'b0;
    logic TCK, TMS, TDI, TDO, TDO_OE, APPLY_STROBE, FORCE_OPERAND;
    logic [31:0] FORCE_OPERAND_VALUE, RESUME_PC_HINT;
    logic [7:0]  n_strobe = 8'h00;
    cpu_scan_pkg::core_state_type ENTRY_STATE, APPLY_STATE, nw, got;
    int err_total = 0;
    int n_tests = 0;
    row_type rows [9] = '{
        '{32'h0000_0000, 32'h0000_0000, 32'h0000_1000},
        '{32'h0001_0000, 32'h0001_0000, 32'h0000_0ffc},
        '{32'h0002_0000, 32'h0002_0000, 32'h0000_0ff8},
        '{32'h0003_0000, 32'h0003_0000, 32'h0000_0ff4},
        '{32'h0004_0000, 32'h0004_0000, 32'h0000_0ff0},
        '{32'h0005_0000, 32'h0005_0000, 32'h0000_0fec},
        '{32'h0006_0000, 32'h0000_0000, 32'h0000_1000},
        '{32'h0005_0800, 32'h0000_0800, 32'h0000_1000},
        '{32'h0000_0402, 32'h0000_0402, 32'h0000_1000}};
    always #5 CORE_CLK = ~CORE_CLK;
    always @(posedge CORE_CLK) begin
        if (APPLY_STROBE === 1'b1) begin
            n_strobe <= n_strobe + 8'h01;
        end
    end
    cpu_debug_scan_chain u_cpu_debug_scan_chain (
        .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .TCK(TCK), .TMS(TMS), .TDI(TDI),
        .TDO(TDO), .TDO_OE(TDO_OE), .CHAIN_SEL(CHAIN_SEL),
        .DEBUG_ENTRY(DEBUG_ENTRY), .ENTRY_STATE(ENTRY_STATE),
        .STEP_DONE(STEP_DONE), .STEP_RESULT_LOW(32'h0000_00aa),
        .STEP_RESULT_HIGH(32'h0000_00bb), .STEP_IS_VECTOR(STEP_IS_VECTOR),
        .APPLY_STATE(APPLY_STATE), .APPLY_STROBE(APPLY_STROBE),
        .FORCE_OPERAND(FORCE_OPERAND), .FORCE_OPERAND_VALUE(FORCE_OPERAND_VALUE),
        .RESUME_PC_HINT(RESUME_PC_HINT));
    jtag_tool u_jtag_tool (.TCK(TCK), .TMS(TMS), .TDI(TDI), .TDO(TDO));
    task automatic cyc(input int n);
        repeat (n) @(negedge CORE_CLK);
    endtask : cyc
    task automatic chk(input logic [191:0] seen, input logic [191:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task automatic step(input logic vec);
        STEP_IS_VECTOR = vec;
        STEP_DONE = 1'b1;
        cyc(1);
        STEP_DONE = 1'b0;
        cyc(3);
    endtask : step
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test
    initial begin
        #400000;
        err_total++;
        finish_test();
    end
    initial begin
        ENTRY_STATE = {32'h0000_0000, 32'h6000_0000, 32'h0000_1000,
                       32'h0000_2000, 32'h0000_0011, 32'h0000_0022};
        // Variable-length no-op, PC one word before 0x4000, state bits clear.
        nw = {32'h0000_0002, 32'h1800_d000,
              32'h0000_3ffc, 32'h0000_2000,
              32'h0000_5678, 32'h0000_def0};
        cyc(10);
        ARST_N = 1'b1;
        cyc(3);
        chk(APPLY_STATE, '0);
        chk({RESUME_PC_HINT, APPLY_STROBE, TDO_OE}, '0);
        foreach (rows[i]) begin
            ENTRY_STATE.ctl = rows[i].ctl_in;
            DEBUG_ENTRY = 1'b1;
            cyc(4);
            chk({APPLY_STATE.ctl, RESUME_PC_HINT},
                rows[i][63:0]);
            chk(FORCE_OPERAND, rows[i].ctl_in[10]);
            DEBUG_ENTRY = i == 8;
            cyc(2);
        end
        CHAIN_SEL = 1'b1;
        u_jtag_tool.scan(nw, got);
        cyc(4);
        chk(got, ENTRY_STATE);
        chk(APPLY_STATE, nw);
        chk(n_strobe, 8'h01);
        step(1'b0);
        chk(APPLY_STATE[63:0], {32'h0000_00aa, nw.wb_high});
        chk(FORCE_OPERAND_VALUE, 32'h0000_00aa);
        step(1'b1);
        chk(APPLY_STATE.wb_high, 32'h0000_00bb);
        // An update outside debug still writes the chain but gives no strobe.
        DEBUG_ENTRY = 1'b0;
        u_jtag_tool.scan(~nw, got);
        cyc(4);
        chk(got, {nw[191:64], 32'h0000_00aa, 32'h0000_00bb});
        chk(APPLY_STATE, ~nw);
        chk(n_strobe, 8'h01);
        CHAIN_SEL = 1'b0;
        u_jtag_tool.scan(nw, got);
        cyc(4);
        chk({APPLY_STATE.pc, n_strobe}, {~nw.pc, 8'h01});
        // A reset in mid-run clears the chain and the outputs.
        ARST_N = 1'b0;
        cyc(2);
        ARST_N = 1'b1;
        cyc(3);
        chk(APPLY_STATE, '0);
        chk({RESUME_PC_HINT, APPLY_STROBE, TDO_OE}, '0);
        finish_test();
    end
endmodule : tb_top
